// ---- logic/video_array_pkg.sv ----
// Overview of operation
// - Index port selects array register for data writes.
// - Status read: inactive, pen latched, switch, retrace.
// - Index zero has no writable bits.
// - Index one holds four-bit palette mask.
// - Index two holds border colour; bit five zero.
// - Index three holds the display mode bits.
// - Indices 10h-1Fh hold sixteen palette entries.
// - Clear port access resets the pen latch.
// - Preset port access sets the pen latch.
// - Extended page bit zero enables extended addressing.
// - Extended page supplies refresh and processor A17/A18.
// - Extended page top bit selects 64K/256K RAM.
// - Page register drives refresh and processor A14-A16.
// - Page register top bits give address mode.
package video_array_pkg;

  // I/O port addresses.
  localparam logic [15:0] INDEX_PORT = 16'h03DA;
  localparam logic [15:0] STATUS_PORT = 16'h03DA;
  localparam logic [15:0] LPEN_CLEAR_PORT = 16'h03DB;
  localparam logic [15:0] LPEN_PRESET_PORT = 16'h03DC;
  localparam logic [15:0] EXT_PAGE_PORT = 16'h03DD;
  localparam logic [15:0] DATA_PORT = 16'h03DE;
  localparam logic [15:0] PAGE_PORT = 16'h03DF;

  // Array register indices.
  localparam int INDEX_W = 5;
  localparam logic [4:0] IDX_NONE = 5'h00;
  localparam logic [4:0] IDX_PAL_MASK = 5'h01;
  localparam logic [4:0] IDX_BORDER = 5'h02;
  localparam logic [4:0] IDX_MODE = 5'h03;
  localparam logic [4:0] IDX_PAL_BASE = 5'h10;
  localparam int PAL_ENTRIES = 16;
  localparam int COLOUR_W = 4;

  // Status read bit positions.
  localparam int ST_INACTIVE_BIT = 0;
  localparam int ST_LPEN_LATCH_BIT = 1;
  localparam int ST_LPEN_SWITCH_BIT = 2;
  localparam int ST_VRETRACE_BIT = 3;

  // Mode control bit positions.
  localparam int MODE_MONO_BIT = 0;
  localparam int MODE_BORDER_EN_BIT = 2;
  localparam int MODE_HIRES4_BIT = 3;
  localparam int MODE_COLOUR16_BIT = 4;
  localparam int MODE_EXTRA_BIT = 5;

  // Reset values.
  localparam logic [4:0] INDEX_RESET = 5'h00;
  localparam logic [3:0] COLOUR_RESET = 4'h0;
  localparam logic [4:0] MODE_RESET = 5'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Mode control fields.
  typedef struct packed {
    logic extra_mode;
    logic colour16;
    logic hires4;
    logic border_en;
    logic mono_en;
  } mode_control_type;

  // Extended RAM page register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic ram_256k;
    logic cpu_a18;
    logic cpu_a17;
    logic crt_a18;
    logic crt_a17;
    logic [1:0] spare;
    logic ext_addr_en;
  } ext_page_type;

  // Video memory relative page register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic [1:0] addr_mode;
    logic [2:0] cpu_page;
    logic [2:0] crt_page;
  } crt_cpu_page_type;

  // Raw status inputs from the display timing and light pen.
  typedef struct packed {
    logic vretrace;
    logic lpen_switch;
    logic lpen_trigger;
    logic display_inactive;
  } video_status_type;

endpackage

// ---- logic/array_field_reg.sv ----
module array_field_reg #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Write side.
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // Stored value.
  output logic [WIDTH-1:0] value_reg
);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      value_reg <= RESET_VALUE;
    end
    else if (wr_en)
    begin
      value_reg <= wr_data;
    end
  end

endmodule

// ---- logic/light_pen_latch.sv ----
module light_pen_latch (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Set and clear sources.
  input wire logic trigger,
  input wire logic preset,
  input wire logic clear,
  // Latched state.
  output logic latched_reg
);

  // A set arriving with a clear wins, so no pen event is lost.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      latched_reg <= 1'b0;
    end
    else if (trigger || preset)
    begin
      latched_reg <= 1'b1;
    end
    else if (clear)
    begin
      latched_reg <= 1'b0;
    end
  end

endmodule

// ---- logic/video_array_regs.sv ----
module video_array_regs (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Processor I/O bus.
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Display timing and light pen inputs.
  input wire video_array_pkg::video_status_type status_in,
  // Array register outputs.
  output logic [3:0] palette_mask,
  output logic [3:0] border_colour,
  output video_array_pkg::mode_control_type mode_control,
  output logic [15:0][3:0] palette,
  // Paging outputs.
  output video_array_pkg::ext_page_type ext_page,
  output video_array_pkg::crt_cpu_page_type crt_cpu_page,
  // Light pen latch state.
  output logic lpen_latched
);

  logic [4:0] index_reg;
  logic [7:0] rdata_reg;
  video_array_pkg::ext_page_type ext_page_reg;
  video_array_pkg::crt_cpu_page_type page_reg;
  logic index_wr;
  logic data_wr;
  logic ext_page_wr;
  logic page_wr;
  logic lpen_clear_hit;
  logic lpen_preset_hit;
  logic mask_wr;
  logic border_wr;
  logic mode_wr;
  logic [15:0] pal_wr;
  logic pal_selected;
  logic [4:0] mode_bits;
  logic [4:0] mode_wdata;

  assign io_rdata = rdata_reg;
  assign ext_page = ext_page_reg;
  assign crt_cpu_page = page_reg;
  assign mode_control = video_array_pkg::mode_control_type'(mode_bits);

  // Address decode of the I/O ports.
  always_comb
  begin
    index_wr = io_wr && (io_addr == video_array_pkg::INDEX_PORT);
    data_wr = io_wr && (io_addr == video_array_pkg::DATA_PORT);
    ext_page_wr = io_wr && (io_addr == video_array_pkg::EXT_PAGE_PORT);
    page_wr = io_wr && (io_addr == video_array_pkg::PAGE_PORT);
    lpen_clear_hit = (io_wr || io_rd) && (io_addr == video_array_pkg::LPEN_CLEAR_PORT);
    lpen_preset_hit = (io_wr || io_rd) && (io_addr == video_array_pkg::LPEN_PRESET_PORT);
  end

  // Index register; data port writes leave it untouched.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      index_reg <= video_array_pkg::INDEX_RESET;
    end
    else if (index_wr)
    begin
      index_reg <= io_wdata[4:0];
    end
  end

  // Data writes steered by the last index; index zero matches nothing.
  always_comb
  begin
    mask_wr = data_wr && (index_reg == video_array_pkg::IDX_PAL_MASK);
    border_wr = data_wr && (index_reg == video_array_pkg::IDX_BORDER);
    mode_wr = data_wr && (index_reg == video_array_pkg::IDX_MODE);
    pal_selected = (index_reg[4] == video_array_pkg::IDX_PAL_BASE[4]);
    for (int i = 0; i < video_array_pkg::PAL_ENTRIES; i++)
    begin
      pal_wr[i] = data_wr && pal_selected && (index_reg[3:0] == 4'(i));
    end
  end

  // Reserved mode bit 1 is not stored.
  always_comb
  begin
    mode_wdata = {io_wdata[video_array_pkg::MODE_EXTRA_BIT],
                  io_wdata[video_array_pkg::MODE_COLOUR16_BIT],
                  io_wdata[video_array_pkg::MODE_HIRES4_BIT],
                  io_wdata[video_array_pkg::MODE_BORDER_EN_BIT],
                  io_wdata[video_array_pkg::MODE_MONO_BIT]};
  end

  array_field_reg #(
    .WIDTH(4),
    .RESET_VALUE(video_array_pkg::COLOUR_RESET)
  ) mask_field (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(mask_wr),
    .wr_data(io_wdata[3:0]),
    .value_reg(palette_mask)
  );

  array_field_reg #(
    .WIDTH(4),
    .RESET_VALUE(video_array_pkg::COLOUR_RESET)
  ) border_field (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(border_wr),
    .wr_data(io_wdata[3:0]),
    .value_reg(border_colour)
  );

  array_field_reg #(
    .WIDTH(5),
    .RESET_VALUE(video_array_pkg::MODE_RESET)
  ) mode_field (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(mode_wr),
    .wr_data(mode_wdata),
    .value_reg(mode_bits)
  );

  // Palette entries keep bits 0 to 3; the upper nibble is dropped.
  for (genvar g = 0; g < video_array_pkg::PAL_ENTRIES; g++)
  begin : gen_palette
    array_field_reg #(
      .WIDTH(4),
      .RESET_VALUE(video_array_pkg::COLOUR_RESET)
    ) entry_field (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .wr_en(pal_wr[g]),
      .wr_data(io_wdata[3:0]),
      .value_reg(palette[g])
    );
  end

  // Extended RAM page register.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ext_page_reg <= video_array_pkg::ext_page_type'(video_array_pkg::PAGE_RESET);
    end
    else if (ext_page_wr)
    begin
      ext_page_reg <= video_array_pkg::ext_page_type'(io_wdata);
    end
  end

  // Video memory relative page register.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      page_reg <= video_array_pkg::crt_cpu_page_type'(video_array_pkg::PAGE_RESET);
    end
    else if (page_wr)
    begin
      page_reg <= video_array_pkg::crt_cpu_page_type'(io_wdata);
    end
  end

  light_pen_latch pen_latch (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .trigger(status_in.lpen_trigger),
    .preset(lpen_preset_hit),
    .clear(lpen_clear_hit),
    .latched_reg(lpen_latched)
  );

  // Read data is registered and held until the next read.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rdata_reg <= video_array_pkg::READ_IDLE;
    end
    else if (io_rd)
    begin
      unique case (io_addr)
        video_array_pkg::STATUS_PORT:
        begin
          rdata_reg <= video_array_pkg::READ_IDLE;
          rdata_reg[video_array_pkg::ST_INACTIVE_BIT] <= status_in.display_inactive;
          rdata_reg[video_array_pkg::ST_LPEN_LATCH_BIT] <= lpen_latched;
          rdata_reg[video_array_pkg::ST_LPEN_SWITCH_BIT] <= status_in.lpen_switch;
          rdata_reg[video_array_pkg::ST_VRETRACE_BIT] <= status_in.vretrace;
        end
        video_array_pkg::EXT_PAGE_PORT:
        begin
          rdata_reg <= ext_page_reg;
        end
        video_array_pkg::PAGE_PORT:
        begin
          rdata_reg <= page_reg;
        end
        default:
        begin
          rdata_reg <= video_array_pkg::READ_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (sys_rst);

  index_write_a: assert property (
    index_wr |=> index_reg == $past(io_wdata[4:0])
  ) else $error("Index port write not captured.");

  index_hold_a: assert property (
    !index_wr |=> $stable(index_reg)
  ) else $error("Index changed without an index write.");

  status_read_a: assert property (
    io_rd && (io_addr == video_array_pkg::STATUS_PORT)
    |=> io_rdata == {4'h0, $past(status_in.vretrace), $past(status_in.lpen_switch),
                     $past(lpen_latched), $past(status_in.display_inactive)}
  ) else $error("Status read returned wrong bits.");

  index_zero_a: assert property (
    data_wr && (index_reg == video_array_pkg::IDX_NONE)
    |=> $stable(palette_mask) && $stable(border_colour) && $stable(mode_bits)
        && $stable(palette)
  ) else $error("Write at index zero changed a register.");

  mask_write_a: assert property (
    data_wr && (index_reg == video_array_pkg::IDX_PAL_MASK)
    |=> palette_mask == $past(io_wdata[3:0]) && $stable(border_colour)
  ) else $error("Palette mask write wrong.");

  border_write_a: assert property (
    data_wr && (index_reg == video_array_pkg::IDX_BORDER)
    |=> border_colour == $past(io_wdata[3:0]) && $stable(palette_mask)
  ) else $error("Border colour write wrong.");

  mode_write_a: assert property (
    data_wr && (index_reg == video_array_pkg::IDX_MODE)
    |=> mode_control.mono_en == $past(io_wdata[0])
        && mode_control.border_en == $past(io_wdata[2])
        && mode_control.extra_mode == $past(io_wdata[5])
  ) else $error("Mode control write wrong.");

  palette_write_a: assert property (
    data_wr && index_reg[4]
    |=> palette[$past(index_reg[3:0])] == $past(io_wdata[3:0])
  ) else $error("Palette entry write wrong.");

  pen_clear_a: assert property (
    lpen_clear_hit && !lpen_preset_hit && !status_in.lpen_trigger |=> !lpen_latched
  ) else $error("Pen clear did not reset latch.");

  pen_preset_a: assert property (
    lpen_preset_hit |=> lpen_latched
  ) else $error("Pen preset did not set latch.");

  ext_enable_a: assert property (
    ext_page_wr |=> ext_page.ext_addr_en == $past(io_wdata[0])
  ) else $error("Extended address enable wrong.");

  ext_lines_a: assert property (
    ext_page_wr |=> {ext_page.cpu_a18, ext_page.cpu_a17, ext_page.crt_a18, ext_page.crt_a17}
                    == $past(io_wdata[6:3])
  ) else $error("Extended address lines wrong.");

  ram_size_a: assert property (
    ext_page_wr |=> ext_page.ram_256k == $past(io_wdata[7])
  ) else $error("RAM size select wrong.");

  page_lines_a: assert property (
    page_wr |=> crt_cpu_page.crt_page == $past(io_wdata[2:0])
                && crt_cpu_page.cpu_page == $past(io_wdata[5:3])
  ) else $error("Page address lines wrong.");

  addr_mode_a: assert property (
    page_wr |=> crt_cpu_page.addr_mode == $past(io_wdata[7:6])
  ) else $error("Video address mode wrong.");

  reset_clear_a: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    sys_rst |=> index_reg == video_array_pkg::INDEX_RESET && palette_mask == 4'h0
                && page_reg == 8'h00 && ext_page_reg == 8'h00 && palette == '0
  ) else $error("Reset did not clear registers.");

  index_then_data_c: cover property (
    index_wr ##[1:4] data_wr ##1 data_wr
  );

  palette_fill_c: cover property (
    data_wr && index_reg == 5'h1F
  );

  pen_cycle_c: cover property (
    lpen_preset_hit ##1 lpen_latched ##[1:8] lpen_clear_hit ##1 !lpen_latched
  );

  paging_c: cover property (
    ext_page_wr ##[1:8] page_wr
  );

endmodule

// ---- tb/io_host_model.sv ----
module io_host_model (
  // Clock.
  input wire logic sys_clk,
  // Processor I/O bus toward the device.
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // Released address and data are inverted so stale values never look valid.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(negedge sys_clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(negedge sys_clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    d = io_rdata;
  endtask

  // Selects an array register when asked, then writes it with reserved bits zero.
  task automatic arr_wr(input logic [4:0] i, input logic [7:0] d, input bit sel);
    logic [7:0] v;
    v = d;
    if (i == 5'h02) v[5] = 1'b0;
    if (i == 5'h03) v[1] = 1'b0;
    if (sel) wr(video_array_pkg::INDEX_PORT, {3'h0, i});
    wr(video_array_pkg::DATA_PORT, v);
  endtask
endmodule

// ---- tb/video_array_regs_tb_top.sv ----
module video_array_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic sys_rst;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  video_array_pkg::video_status_type status_in;
  logic [3:0] palette_mask;
  logic [3:0] border_colour;
  video_array_pkg::mode_control_type mode_control;
  logic [15:0][3:0] palette;
  video_array_pkg::ext_page_type ext_page;
  video_array_pkg::crt_cpu_page_type crt_cpu_page;
  logic lpen_latched;
  int n_mismatch;
  int n_checks;
  int seed;
  logic [3:0] m_pal[16];
  logic [3:0] m_mask;
  logic [4:0] m_idx;
  logic [3:0] m_border;
  logic [4:0] m_mode;
  logic [7:0] m_ext;
  logic [7:0] m_page;
  logic m_lat;
  logic [7:0] rv;
  logic [4:0] idx;
  bit sel;

  video_array_regs DUT (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .io_addr(io_addr),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .status_in(status_in),
    .palette_mask(palette_mask),
    .border_colour(border_colour),
    .mode_control(mode_control),
    .palette(palette),
    .ext_page(ext_page),
    .crt_cpu_page(crt_cpu_page),
    .lpen_latched(lpen_latched)
  );

  io_host_model HOST (
    .sys_clk(sys_clk),
    .io_addr(io_addr),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (e !== s)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic check_all();
    chk("palette_mask", {4'h0, m_mask}, {4'h0, palette_mask});
    chk("border_colour", {4'h0, m_border}, {4'h0, border_colour});
    chk("mode_control", {3'h0, m_mode}, {3'h0, mode_control});
    chk("ext_page", m_ext, ext_page);
    chk("crt_cpu_page", m_page, crt_cpu_page);
    chk("lpen_latched", {7'h00, m_lat}, {7'h00, lpen_latched});
    for (int i = 0; i < 16; i++) chk("palette", {4'h0, m_pal[i]}, {4'h0, palette[i]});
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    sys_rst <= 1'b1;
    repeat (6) @(negedge sys_clk);
    sys_rst <= 1'b0;
    m_idx = 5'h00;
    m_mask = 4'h0;
    m_border = 4'h0;
    m_mode = 5'h00;
    m_ext = 8'h00;
    m_page = 8'h00;
    m_lat = 1'b0;
    for (int i = 0; i < 16; i++) m_pal[i] = 4'h0;
  endtask

  // Array write through the host, mirrored into the reference state.
  task automatic arr(input logic [4:0] i, input logic [7:0] d, input bit s);
    HOST.arr_wr(i, d, s);
    if (s) m_idx = i;
    if (m_idx[4]) m_pal[m_idx[3:0]] = d[3:0];
    else if (m_idx == 5'h01) m_mask = d[3:0];
    else if (m_idx == 5'h02) m_border = d[3:0];
    else if (m_idx == 5'h03) m_mode = {d[5:2], d[0]};
  endtask

  initial
  begin
    repeat (50000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    sys_rst = 1'b1;
    status_in = 4'h0;
    seed = 32'h1C26990F;
    n_mismatch = 0;
    n_checks = 0;
    do_reset();
    check_all();
    $display("test reset done");
    for (int k = 0; k < 32; k++)
    begin
      arr(5'(k), ~8'(k), 1'b1);
      check_all();
    end
    idx = 5'h01;
    for (int k = 0; k < 80; k++)
    begin
      sel = ($random(seed) & 3) == 0;
      if (sel) idx = 5'($random(seed));
      arr(idx, 8'($random(seed)), sel);
      check_all();
    end
    $display("test array done");
    for (int k = 0; k < 8; k++)
    begin
      @(negedge sys_clk);
      status_in <= 4'($random(seed)) & 4'hD;
      HOST.rd(video_array_pkg::STATUS_PORT, rv);
      chk("status", {4'h0, status_in[3:2], m_lat, status_in[0]}, rv);
      case (k % 4)
        0: HOST.wr(video_array_pkg::LPEN_PRESET_PORT, 8'($random(seed)));
        1: HOST.rd(video_array_pkg::LPEN_CLEAR_PORT, rv);
        2: HOST.rd(video_array_pkg::LPEN_PRESET_PORT, rv);
        default: HOST.wr(video_array_pkg::LPEN_CLEAR_PORT, 8'($random(seed)));
      endcase
      m_lat = (k % 2) == 0;
      check_all();
    end
    @(negedge sys_clk);
    status_in <= 4'h2;
    @(negedge sys_clk);
    status_in <= 4'h0;
    m_lat = 1'b1;
    HOST.rd(video_array_pkg::STATUS_PORT, rv);
    chk("status", 8'h02, rv);
    HOST.wr(video_array_pkg::LPEN_CLEAR_PORT, 8'h00);
    m_lat = 1'b0;
    check_all();
    $display("test light pen done");
    for (int k = 0; k < 20; k++)
    begin
      m_ext = 8'($random(seed));
      m_page = 8'($random(seed));
      HOST.wr(video_array_pkg::EXT_PAGE_PORT, m_ext);
      HOST.wr(video_array_pkg::PAGE_PORT, m_page);
      check_all();
      HOST.rd(video_array_pkg::EXT_PAGE_PORT, rv);
      chk("ext_page_read", m_ext, rv);
      HOST.rd(video_array_pkg::PAGE_PORT, rv);
      chk("page_read", m_page, rv);
    end
    HOST.rd(video_array_pkg::DATA_PORT, rv);
    chk("unmapped_read", 8'h00, rv);
    $display("test paging done");
    do_reset();
    check_all();
    HOST.rd(video_array_pkg::PAGE_PORT, rv);
    chk("page_read", 8'h00, rv);
    arr(5'h02, 8'h0F, 1'b0);
    check_all();
    $display("test second reset done");
    conclude();
  end
endmodule
